/* File: vis_pkg.sv */
package vis_pkg;

  // ==========================================================================
  // Register offsets (byte addresses in the special function area)
  localparam logic [7:0] VIS_UPPER_ENABLE_OFS = 8'h2C;
  localparam logic [7:0] VIS_UPPER_LATCH_OFS = 8'h2E;
  localparam logic [7:0] VIS_LOWER_ENABLE_OFS = 8'h3A;
  localparam logic [7:0] VIS_LOWER_LATCH_OFS = 8'h3C;

  // ==========================================================================
  // Source numbering and field positions
  localparam int VIS_NSRC = 32;
  localparam int VIS_SRC_SW = 1;
  localparam int VIS_SRC_WDT = 2;
  localparam int VIS_SRC_EXT0 = 3;
  localparam int VIS_MASTER_BIT = 0;
  localparam int VIS_BANK_ADD_W = 4;
  localparam logic [31:0] VIS_LATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] VIS_ENABLE_RESET = 32'h0000_0000;
  localparam logic [15:0] VIS_LOW_LATCH_UNDEF = 16'hFFFC;

  // ==========================================================================
  // Vector table top and per-slot stride
  localparam logic [19:0] VIS_VECTOR_TOP = 20'hFFFFC;
  localparam logic [19:0] VIS_VECTOR_STRIDE = 20'h00004;

  // ==========================================================================
  // Acceptance timing in machine cycles
  localparam int VIS_ACCEPT_CYCLES = 12;
  localparam int VIS_STACK_BYTES = 5;
  localparam logic [7:0] VIS_TRAP_OPCODE = 8'hFF;
  localparam logic [3:0] VIS_CNT_W_MAX = 4'hF;

  typedef enum logic [2:0] {
    VIS_ST_IDLE,
    VIS_ST_PUSH,
    VIS_ST_VEC,
    VIS_ST_WAIT,
    VIS_ST_DONE
  } vis_state_e;

  // Register bus access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } vis_sfr_s;

  // Sequencer-side status handed to the core
  typedef struct packed {
    logic push_stb;
    logic [2:0] push_idx;
    logic vec_stb;
    logic [19:0] vec_addr;
    logic start;
  } vis_seq_s;

endpackage : vis_pkg

/* File: vis_sequencer.sv */
`timescale 1ns/10ps
// Functional notes
// - Maskable source except external zero accepted only when its enable flag is one.
// - Pending request stays latched until accepted, reset or cleared by a store.
// - Acceptance sequence takes 12 machine cycles after the instruction ends.
// - Acceptance clears master enable; pseudo non-maskable blocks all further interrupts (here maskable ones only while master enable stays zero).
// - Acceptance clears only the accepted source's latch.
// - Push status high, status low, counter ext, high, low; stack pointer down each.
// - Service entry address read from the accepted source's vector slot into counter.
// - Bank code fetched from vector table; low 4 bits added to bank selector.
// - Master enable zero blocks all maskable requests, even higher priority ones.
// - Maskable return pops counter and status, five increments, sets master enable.
// - Non-maskable return sets master enable only if it was one at acceptance.
// - Both returns decrement nesting counter and update nesting flag.
// - Bank selector restored with status word on both returns.
// - Requests sampled in instruction's final cycle; accept right after a return.
// - Trap instruction raises software interrupt immediately at highest priority.
// - Trap during pseudo non-maskable service acts as no operation.
// - Fetch from non-existent address returns FF, the trap opcode.
// - Fetch from RAM, function or buffer areas raises address-trap reset.
// - Low latch byte bits 1 and 0 read undefined.
// - Lowest source index wins among pending enabled requests.
// - Requests set latches; writes only clear; reset clears all.
// - Pseudo non-maskable ignores enables but never nests.
// - Master enable is bit 0 of low enable byte, reset to zero.
module vis_sequencer
  import vis_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Request sources (asynchronous pins, synchronised inside)
  input wire logic [VIS_NSRC-1:0] src_req,
  input wire logic ext0_en,
  // Register access from the core
  input wire vis_sfr_s special_function_area,
  output logic [15:0] sfr_rdata,
  // Instruction sequencer handshake
  input wire logic instr_last,
  input wire logic trap_op,
  input wire logic ret_mask_op,
  input wire logic ret_nmask_op,
  input wire logic fetch,
  input wire logic fetch_exists,
  input wire logic fetch_internal,
  input wire logic [7:0] fetch_byte,
  output logic [7:0] fetch_data,
  output logic addr_trap_rst,
  // Stack, vector and bank interface
  input wire logic [3:0] bank_code,
  input wire logic [3:0] bank_restore,
  output vis_seq_s seq,
  output logic [3:0] bank_sel,
  output logic sp_dec,
  output logic sp_inc,
  output logic busy,
  output logic master_enable,
  output logic nest_flag
);

  // ==========================================================================
  // Request pin synchroniser (two stages)
  // Requests arrive asynchronously, so two stages guard against metastability
  // Third stage only feeds the edge detector; the first stage only feeds the second
  logic [VIS_NSRC-1:0] req_m_q, req_s_q, req_p_q;
  logic [VIS_NSRC-1:0] req_m_d, req_s_d, req_p_d;
  always_comb begin
    req_m_d = src_req;
    req_s_d = req_m_q;
    req_p_d = req_s_q;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_m_q <= '0;
      req_s_q <= '0;
      req_p_q <= '0;
    end else if (clk_en) begin
      req_m_q <= req_m_d;
      req_s_q <= req_s_d;
      req_p_q <= req_p_d;
    end
  end
  logic [VIS_NSRC-1:0] req_rise;
  assign req_rise = req_s_q & ~req_p_q;

  // ==========================================================================
  // Registers and control state
  logic [VIS_NSRC-1:0] latch_q, latch_d;
  logic [VIS_NSRC-1:0] enable_q, enable_d;
  logic nmi_busy_q, nmi_busy_d;
  logic nmi_saved_q, nmi_saved_d;
  logic [3:0] nest_q, nest_d;
  logic [3:0] bank_q, bank_d;
  vis_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [4:0] sel_q, sel_d;
  vis_seq_s seq_q, seq_d;
  logic sp_dec_q, sp_dec_d, sp_inc_q, sp_inc_d;
  logic [2:0] inc_left_q, inc_left_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0] fdata_q, fdata_d;
  logic trap_rst_q, trap_rst_d;
  // Status flags kept in flip-flops so the core sees clean levels
  logic busy_q, busy_d;
  logic nest_flag_q, nest_flag_d;
  logic [VIS_NSRC-1:0] rise_ok;

  // Priority pick: lowest index wins
  // Scan runs downward so the last hit, the lowest index, is kept
  logic [VIS_NSRC-1:0] eligible;
  logic found;
  logic [4:0] pick;
  always_comb begin
    eligible = '0;
    eligible[VIS_SRC_WDT] = latch_q[VIS_SRC_WDT] & ~nmi_busy_q;
    if (enable_q[VIS_MASTER_BIT]) begin
      for (int i = VIS_SRC_EXT0 + 1; i < VIS_NSRC; i++) begin
        eligible[i] = latch_q[i] & enable_q[i];
      end
      eligible[VIS_SRC_EXT0] = latch_q[VIS_SRC_EXT0] & ext0_en;
    end
    found = 1'b0;
    pick = '0;
    for (int i = VIS_NSRC - 1; i >= VIS_SRC_WDT; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        pick = 5'(i);
      end
    end
  end

  // Next-state computation
  always_comb begin
    latch_d = latch_q;
    enable_d = enable_q;
    nmi_busy_d = nmi_busy_q;
    nmi_saved_d = nmi_saved_q;
    nest_d = nest_q;
    bank_d = bank_q;
    st_d = st_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    seq_d = '0;
    seq_d.push_idx = seq_q.push_idx;
    seq_d.vec_addr = seq_q.vec_addr;
    sp_dec_d = 1'b0;
    sp_inc_d = 1'b0;
    inc_left_d = inc_left_q;
    // writes clear latches with plain store value
    if (special_function_area.wr && special_function_area.addr == VIS_LOWER_LATCH_OFS) begin
      latch_d[15:0] = latch_q[15:0] & special_function_area.wdata;
      latch_d[VIS_SRC_WDT] = latch_q[VIS_SRC_WDT];
    end
    if (special_function_area.wr && special_function_area.addr == VIS_UPPER_LATCH_OFS) begin
      latch_d[31:16] = latch_q[31:16] & special_function_area.wdata;
    end
    if (special_function_area.wr && special_function_area.addr == VIS_LOWER_ENABLE_OFS) begin
      // master enable bit 0 of low byte
      enable_d[15:0] = special_function_area.wdata;
      enable_d[2:1] = 2'b00;
    end
    if (special_function_area.wr && special_function_area.addr == VIS_UPPER_ENABLE_OFS) begin
      enable_d[31:16] = special_function_area.wdata;
    end
    // Return and a new acceptance may coincide; the acceptance below then wins
    // return operations
    if (instr_last && (ret_mask_op || ret_nmask_op) && st_q == VIS_ST_IDLE) begin
      inc_left_d = 3'(VIS_STACK_BYTES);
      bank_d = bank_restore;
      if (nest_q != '0) begin
        nest_d = nest_q - 4'h1;
      end
      if (ret_mask_op) begin
        enable_d[VIS_MASTER_BIT] = 1'b1;
      end else begin
        enable_d[VIS_MASTER_BIT] = nmi_saved_q;
        nmi_busy_d = 1'b0;
      end
    end
    if (inc_left_q != '0) begin
      sp_inc_d = 1'b1;
      inc_left_d = inc_left_q - 3'h1;
    end
    unique case (st_q)
      VIS_ST_IDLE: begin
        // sample at final cycle of each instruction
        if (instr_last) begin
          // trap highest, no operation inside pseudo non-maskable
          if (trap_op && !nmi_busy_q) begin
            sel_d = 5'(VIS_SRC_SW);
            st_d = VIS_ST_PUSH;
          end else if (found && !(trap_op && nmi_busy_q)) begin
            sel_d = pick;
            st_d = VIS_ST_PUSH;
            latch_d[pick] = 1'b0;
          end
          if (st_d == VIS_ST_PUSH) begin
            cnt_d = '0;
            seq_d.start = 1'b1;
            nest_d = nest_q + 4'h1;
            enable_d[VIS_MASTER_BIT] = 1'b0;
            if (sel_d <= 5'(VIS_SRC_WDT)) begin
              nmi_busy_d = 1'b1;
              nmi_saved_d = enable_q[VIS_MASTER_BIT];
            end
          end
        end
      end
      VIS_ST_PUSH: begin
        // five byte pushes in fixed order
        seq_d.push_stb = 1'b1;
        seq_d.push_idx = cnt_q[2:0];
        sp_dec_d = 1'b1;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(VIS_STACK_BYTES - 1)) begin
          st_d = VIS_ST_VEC;
        end
      end
      VIS_ST_VEC: begin
        // Slot address steps down from the top of the table by source index
        // vector slot of selected source only
        seq_d.vec_stb = 1'b1;
        seq_d.vec_addr = VIS_VECTOR_TOP - VIS_VECTOR_STRIDE * 20'(sel_q);
        cnt_d = cnt_q + 4'h1;
        st_d = VIS_ST_WAIT;
      end
      VIS_ST_WAIT: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(VIS_ACCEPT_CYCLES - 2)) begin
          st_d = VIS_ST_DONE;
          bank_d = bank_q + bank_code[VIS_BANK_ADD_W-1:0];
        end
      end
      VIS_ST_DONE: begin
        st_d = VIS_ST_IDLE;
      end
    endcase
    // requests set latches, set beats clear
    // A disabled external zero pin may not set its latch at all
    rise_ok = req_rise;
    if (!ext0_en) begin
      rise_ok[VIS_SRC_EXT0] = 1'b0;
    end
    latch_d = latch_d | rise_ok;
    latch_d[VIS_SRC_SW] = 1'b0;
    // Flags follow the next state so they leave a flip-flop
    busy_d = (st_d != VIS_ST_IDLE);
    nest_flag_d = (nest_d != '0);
  end

  // Read data, fetch substitution and address trap
  always_comb begin
    // Read data holds until the next read so the core may take it late
    rdata_d = rdata_q;
    if (special_function_area.rd) begin
      unique case (special_function_area.addr)
        // low two bits undefined, returned as ones
        VIS_LOWER_LATCH_OFS: rdata_d = latch_q[15:0] | ~VIS_LOW_LATCH_UNDEF;
        VIS_UPPER_LATCH_OFS: rdata_d = latch_q[31:16];
        VIS_LOWER_ENABLE_OFS: rdata_d = enable_q[15:0];
        VIS_UPPER_ENABLE_OFS: rdata_d = enable_q[31:16];
        default: rdata_d = '0;
      endcase
    end
    fdata_d = (fetch && !fetch_exists) ? VIS_TRAP_OPCODE : fetch_byte;
    trap_rst_d = fetch && fetch_internal;
  end

  // Register all state
  // Clock enable low freezes every flip-flop below
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= VIS_LATCH_RESET;
      enable_q <= VIS_ENABLE_RESET;
      nmi_busy_q <= 1'b0;
      nmi_saved_q <= 1'b0;
      nest_q <= '0;
      bank_q <= '0;
      st_q <= VIS_ST_IDLE;
      cnt_q <= '0;
      sel_q <= '0;
      seq_q <= '0;
      sp_dec_q <= 1'b0;
      sp_inc_q <= 1'b0;
      inc_left_q <= '0;
      rdata_q <= '0;
      fdata_q <= '0;
      trap_rst_q <= 1'b0;
      busy_q <= 1'b0;
      nest_flag_q <= 1'b0;
    end else if (clk_en) begin
      latch_q <= latch_d;
      enable_q <= enable_d;
      nmi_busy_q <= nmi_busy_d;
      nmi_saved_q <= nmi_saved_d;
      nest_q <= nest_d;
      bank_q <= bank_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      seq_q <= seq_d;
      sp_dec_q <= sp_dec_d;
      sp_inc_q <= sp_inc_d;
      inc_left_q <= inc_left_d;
      rdata_q <= rdata_d;
      fdata_q <= fdata_d;
      trap_rst_q <= trap_rst_d;
      busy_q <= busy_d;
      nest_flag_q <= nest_flag_d;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata = rdata_q;
  assign fetch_data = fdata_q;
  assign addr_trap_rst = trap_rst_q;
  assign seq = seq_q;
  assign bank_sel = bank_q;
  assign sp_dec = sp_dec_q;
  assign sp_inc = sp_inc_q;
  assign busy = busy_q;
  assign master_enable = enable_q[VIS_MASTER_BIT];
  assign nest_flag = nest_flag_q;

endmodule : vis_sequencer

/* File: vis_sequencer_sva.sv */
`timescale 1ns/10ps
module vis_sequencer_chk
  import vis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core handshake and fetch
  input wire logic instr_last,
  input wire logic ret_mask_op,
  input wire logic ret_nmask_op,
  input wire logic fetch,
  input wire logic fetch_exists,
  input wire logic fetch_internal,
  input wire logic [7:0] fetch_byte,
  input wire logic [7:0] fetch_data,
  input wire logic addr_trap_rst,
  // Sequencer side
  input wire logic [3:0] bank_code,
  input wire vis_seq_s seq,
  input wire logic [3:0] bank_sel,
  input wire logic sp_dec,
  input wire logic sp_inc,
  input wire logic busy,
  input wire logic master_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // Acceptance, fetch and return
  start_mask_a: assert property (seq.start |-> !master_enable)
    else $error("master enable kept at start");
  push_run_a: assert property (seq.start |=> (seq.push_stb && sp_dec)[*5] ##1 seq.vec_stb)
    else $error("push run wrong");
  push_ends_a: assert property (seq.start |=> seq.push_idx == 3'h0 ##4 seq.push_idx == 3'h4)
    else $error("push order wrong");
  accept_len_a: assert property (seq.start |-> ##11 busy ##1 !busy)
    else $error("acceptance length wrong");
  bank_add_a: assert property (seq.start |-> ##12 bank_sel == 4'($past(bank_sel, 12) + bank_code))
    else $error("bank offset wrong");
  fetch_trap_a: assert property (fetch && !fetch_exists |=> fetch_data == VIS_TRAP_OPCODE)
    else $error("missing fetch not trap code");
  fetch_pass_a: assert property (!(fetch && !fetch_exists) |=> fetch_data == $past(fetch_byte))
    else $error("fetched byte not passed");
  addr_trap_a: assert property (addr_trap_rst == $past(fetch && fetch_internal))
    else $error("address trap pulse wrong");
  ret_enable_a: assert property (instr_last && ret_mask_op && !busy |-> ##[1:8] master_enable)
    else $error("return left master off");
  ret_stack_a: assert property (instr_last && (ret_mask_op || ret_nmask_op) && !busy |-> ##2 sp_inc[*5] ##1 !sp_inc)
    else $error("return stack steps wrong");
  // Main scenarios seen
  cover property (seq.start);
  cover property (seq.vec_stb && !master_enable);
  cover property (addr_trap_rst);
  cover property (sp_inc);
endmodule : vis_sequencer_chk

bind vis_sequencer vis_sequencer_chk chk (.clk, .rst_b, .instr_last, .ret_mask_op, .ret_nmask_op,
  .fetch, .fetch_exists, .fetch_internal, .fetch_byte, .fetch_data, .addr_trap_rst, .bank_code,
  .seq, .bank_sel, .sp_dec, .sp_inc, .busy, .master_enable);

/* File: vis_src_model.sv */
`timescale 1ns/10ps
module vis_src_model
  import vis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command from the bench
  input wire logic fire,
  input wire logic [4:0] idx,
  // Request lines
  output logic [VIS_NSRC-1:0] src_req
);
  // ====================
  // One-cycle request pulse, low between requests so every pulse is an edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_req <= '0;
    end else begin
      src_req <= fire ? (VIS_NSRC'(1) << idx) : '0;
    end
  end
endmodule : vis_src_model

/* File: tb.sv */
`timescale 1ns/10ps
module tb
  import vis_pkg::*;
;
  logic clk, rst_b, ext0_en, instr_last, trap_op, ret_mask_op, ret_nmask_op;
  logic fetch, fetch_exists, fetch_internal, fire;
  logic addr_trap_rst, sp_dec, sp_inc, busy, master_enable, nest_flag;
  logic [7:0] fetch_byte, fetch_data;
  logic [3:0] bank_code, bank_restore, bank_sel;
  logic [4:0] idx;
  logic [VIS_NSRC-1:0] src_req;
  logic [15:0] sfr_rdata;
  vis_sfr_s special_function_area;
  vis_seq_s seq;
  int error_cnt = 0;
  int n_compared = 0;

  // ====================
  // Design and request source
  vis_sequencer dut (.clk, .rst_b, .clk_en(1'b1), .src_req, .ext0_en, .special_function_area, .sfr_rdata,
    .instr_last, .trap_op, .ret_mask_op, .ret_nmask_op, .fetch, .fetch_exists,
    .fetch_internal, .fetch_byte, .fetch_data, .addr_trap_rst, .bank_code, .bank_restore,
    .seq, .bank_sel, .sp_dec, .sp_inc, .busy, .master_enable, .nest_flag);
  vis_src_model src (.clk, .rst_b, .fire, .idx, .src_req);

  // Clock
  always #5 clk = ~clk;

  // Vector slot of a source
  function automatic logic [19:0] vec(input int k);
    return VIS_VECTOR_TOP - VIS_VECTOR_STRIDE * 20'(k);
  endfunction : vec

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // plain stores only, flags and latches changed with master off
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) special_function_area <= '{1'b1, 1'b0, a, d};
    @(posedge clk) special_function_area <= '0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) special_function_area <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) special_function_area <= '0;
    #1 chk(20'(sfr_rdata), 20'(e));
  endtask : rdchk

  task automatic raise(input int k);
    @(posedge clk) fire <= 1'b1;
    idx <= 5'(k);
    @(posedge clk) fire <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : raise

  // One instruction end; va gets the vector read, all ones if none
  task automatic issue(input logic t, input logic rm, input logic rn, output logic [19:0] va);
    int n;
    va = 20'hFFFFF;
    @(posedge clk) {instr_last, trap_op, ret_mask_op, ret_nmask_op} <= {1'b1, t, rm, rn};
    @(posedge clk) {instr_last, trap_op, ret_mask_op, ret_nmask_op} <= 4'h0;
    for (n = 0; n < 16; n++) begin
      #1;
      if (seq.vec_stb === 1'b1) va = seq.vec_addr;
      if (n > 2 && busy === 1'b0) break;
      @(posedge clk);
    end
    if (n == 16) begin
      error_cnt++;
      $display("Error at %0t: acceptance did not finish", $time);
      stop_test();
    end else begin
      repeat (6) @(posedge clk);
      #1;
    end
  endtask : issue

  initial begin
    logic [19:0] va;
    int k1, k2;
    {clk, rst_b, instr_last, trap_op, ret_mask_op, ret_nmask_op} = 6'h00;
    {fetch, fetch_exists, fetch_internal, fire, fetch_byte} = 12'h000;
    {bank_code, bank_restore, idx} = 13'h0000;
    special_function_area = '0;
    ext0_en = 1'b1;
    k1 = $urandom(32'h167a);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped address reads zero
    rdchk(VIS_UPPER_ENABLE_OFS, 16'h0000);
    rdchk(VIS_UPPER_LATCH_OFS, 16'h0000);
    rdchk(VIS_LOWER_ENABLE_OFS, 16'h0000);
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF);
    rdchk(8'h00, 16'h0000);
    // Two pending sources; flags written with master off
    wr(VIS_UPPER_ENABLE_OFS, 16'hFFFF);
    wr(VIS_LOWER_ENABLE_OFS, 16'hFFFE);
    rdchk(VIS_LOWER_ENABLE_OFS, 16'hFFF8);
    k1 = 4 + $urandom % 6;
    k2 = k1 + 1 + $urandom % 8;
    raise(k1);
    raise(k2);
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF | 16'((32'h1 << k1) | (32'h1 << k2)));
    wr(VIS_LOWER_ENABLE_OFS, 16'hFFF9);
    bank_code <= 4'($urandom);
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, vec(k1));
    chk(20'(bank_sel), 20'(bank_code));
    chk(20'(master_enable), 20'h0);
    chk(20'(nest_flag), 20'h1);
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF | 16'(32'h1 << k2));
    rdchk(VIS_UPPER_LATCH_OFS, 16'((32'h1 << k2) >> 16));
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, 20'hFFFFF);
    @(posedge clk) bank_restore <= 4'($urandom);
    issue(1'b0, 1'b1, 1'b0, va);
    chk(20'(master_enable), 20'h1);
    chk(20'(bank_sel), 20'(bank_restore));
    chk(20'(nest_flag), 20'h0);
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, vec(k2));
    issue(1'b0, 1'b1, 1'b0, va);
    // Flag clear blocks a source; stores only clear latches
    wr(VIS_LOWER_ENABLE_OFS, 16'h0000);
    wr(VIS_LOWER_ENABLE_OFS, 16'h0001);
    raise(k1);
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, 20'hFFFFF);
    wr(VIS_LOWER_ENABLE_OFS, 16'h0000);
    wr(VIS_LOWER_LATCH_OFS, 16'hFFFF);
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF | 16'(32'h1 << k1));
    wr(VIS_LOWER_LATCH_OFS, ~16'(32'h1 << k1));
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF);
    // External source zero: pin enable gates it, its own flag does not
    @(posedge clk) ext0_en <= 1'b0;
    raise(VIS_SRC_EXT0);
    rdchk(VIS_LOWER_LATCH_OFS, ~VIS_LOW_LATCH_UNDEF);
    @(posedge clk) ext0_en <= 1'b1;
    raise(VIS_SRC_EXT0);
    wr(VIS_LOWER_ENABLE_OFS, 16'h0001);
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, vec(VIS_SRC_EXT0));
    issue(1'b0, 1'b1, 1'b0, va);
    wr(VIS_LOWER_ENABLE_OFS, 16'h0000);
    // Trap beats a pending source; watchdog taken with master off
    // service routines below never set master enable themselves
    raise(k1);
    wr(VIS_LOWER_ENABLE_OFS, 16'hFFF9);
    issue(1'b1, 1'b0, 1'b0, va);
    chk(va, vec(VIS_SRC_SW));
    issue(1'b0, 1'b0, 1'b1, va);
    chk(20'(master_enable), 20'h1);
    wr(VIS_LOWER_ENABLE_OFS, 16'h0000);
    raise(VIS_SRC_WDT);
    issue(1'b0, 1'b0, 1'b0, va);
    chk(va, vec(VIS_SRC_WDT));
    issue(1'b1, 1'b0, 1'b0, va);
    chk(va, 20'hFFFFF);
    issue(1'b0, 1'b0, 1'b1, va);
    chk(20'(master_enable), 20'h0);
    // Random fetch traffic for the checker
    repeat (40) begin
      @(posedge clk) {fetch, fetch_exists, fetch_internal} <= 3'($urandom);
      fetch_byte <= 8'($urandom);
    end
    stop_test();
  end
endmodule : tb
